// [design/agt_cfg.svh]
// Register offsets, field positions, reset values and counts for the gain and lock block
`ifndef AGT_CFG_SVH
`define AGT_CFG_SVH

`define AGT_ADDR_W 7
`define AGT_OFS_GAIN_DOWN 7'h13
`define AGT_OFS_GAIN_UP 7'h14
`define AGT_OFS_LOCK_CTL 7'h15

// Reset values: margins 1, level and max gain 24, lock control 0
`define AGT_RST_GAIN_DOWN 8'h38
`define AGT_RST_GAIN_UP 8'h38
`define AGT_RST_LOCK_CTL 8'h00

// Field positions
`define AGT_MARGIN_HI 7
`define AGT_MARGIN_LO 5
`define AGT_LEVEL_HI 4
`define AGT_LEVEL_LO 0
`define AGT_SEL_HI 7
`define AGT_SEL_LO 4
`define AGT_WIN_BIT 3
`define AGT_MODE_BIT 2
`define AGT_ACC_HI 1
`define AGT_ACC_LO 0

// Gain loop offsets in 1.5 dB steps
`define AGT_UP_BASE 8'h08
`define AGT_DOWN_BASE 8'h03

// Lock window widths in prescaler cycles
`define AGT_WIN_NARROW 3'h2
`define AGT_WIN_WIDE 3'h4

// Lock thresholds: lock at 2^(7+code)-1, unlock sixteen below
`define AGT_LOCK_TH0 10'h07f
`define AGT_LOCK_GAP 10'h010
`define AGT_CNT_MAX 10'h3ff

`endif

// [design/agt_pkg.sv]
// Types shared by the gain and lock block
package agt_pkg;

	typedef enum logic {
		AGT_UNLOCKED = 1'b0,
		AGT_LOCKED = 1'b1
	} agt_lock_state_type;

	typedef enum logic {
		AGT_MODE_RESTART = 1'b0,
		AGT_MODE_UPDOWN = 1'b1
	} agt_lock_mode_type;

	typedef enum logic [3:0] {
		AGT_SRC_LOW = 4'h0,
		AGT_SRC_HIGH = 4'h1,
		AGT_SRC_LOCK_FILT = 4'h2,
		AGT_SRC_LOCK_RAW = 4'h3,
		AGT_SRC_CARRIER = 4'h4,
		AGT_SRC_CAL = 4'h5,
		AGT_SRC_SEQ = 4'h6
	} agt_pin_src_type;

endpackage : agt_pkg

// [design/agt_lock_if.sv]
// Connection between the register block and the lock detector
`timescale 1ns/1ns
interface agt_lock_if;
	import agt_pkg::*;
	logic wide_window;
	agt_lock_mode_type mode;
	logic [1:0] accuracy;
	logic cmp_valid;
	logic [2:0] cmp_error;
	logic locked;
	logic raw_in_window;

	modport ctl (
		output wide_window, mode, accuracy, cmp_valid, cmp_error,
		input locked, raw_in_window
	);
	modport det (
		input wide_window, mode, accuracy, cmp_valid, cmp_error,
		output locked, raw_in_window
	);
endinterface : agt_lock_if

// [design/agt_lock_det.sv]
// Phase lock detector with restart and up/down counting and threshold hysteresis
`timescale 1ns/1ns
`include "agt_cfg.svh"
module agt_lock_det
	import agt_pkg::*;
(
	input wire logic i_mclk, // System clock
	input wire logic i_rstn, // Async reset, active low
	agt_lock_if.det lk // Control in, lock status out
);

	logic [9:0] count;
	logic [9:0] next_count;
	agt_lock_state_type state;
	agt_lock_state_type next_state;
	logic raw;
	logic next_raw;
	logic in_win;
	logic [9:0] lock_th;
	logic [9:0] unlock_th;

	////////////////////////////////////////////////////////////////////////
	// Window test and thresholds
	always_comb begin
		in_win = lk.cmp_error < (lk.wide_window ? `AGT_WIN_WIDE : `AGT_WIN_NARROW);
		lock_th = 10'((({1'b0, `AGT_LOCK_TH0} + 11'h001) << lk.accuracy) - 11'h001);
		unlock_th = lock_th - `AGT_LOCK_GAP;
	end

	////////////////////////////////////////////////////////////////////////
	// Counter and lock state; counter saturates so a long lock never wraps
	always_comb begin
		next_count = count;
		next_state = state;
		next_raw = raw;
		if (lk.cmp_valid) begin
			next_raw = in_win;
			if (in_win) begin
				if (count != `AGT_CNT_MAX) begin
					next_count = count + 10'h001;
				end
			end else if (lk.mode == AGT_MODE_RESTART) begin
				next_count = 10'h000;
			end else if (count != 10'h000) begin
				next_count = count - 10'h001;
			end
		end
		case (state)
			AGT_UNLOCKED: begin
				if (next_count >= lock_th) begin
					next_state = AGT_LOCKED;
				end
			end
			AGT_LOCKED: begin
				if (next_count <= unlock_th) begin
					next_state = AGT_UNLOCKED;
				end
			end
			default: begin
				next_state = AGT_UNLOCKED;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			count <= 10'h000;
			state <= AGT_UNLOCKED;
			raw <= 1'b0;
		end else begin
			count <= next_count;
			state <= next_state;
			raw <= next_raw;
		end
	end

	assign lk.locked = (state == AGT_LOCKED);
	assign lk.raw_in_window = raw;

endmodule : agt_lock_det

// [design/agt_top.sv]
// Gain loop thresholds, lock detection and status pin selection
//
// Summary of operation
// - Lower gain above level+8+up+3+down
// - Raise gain below level+8+up, under maximum
// - Strength input has 1.5 dB steps
// - Load maximum gain at receive power-on
// - Gain loop never raises past maximum gain; a lowered maximum clamps it one edge later
// - Carrier level shared by detect and loop
// - Pin codes 0..6: low, high, flags
// - Code 4 pin low on carrier
// - Lock window 2 or 4 cycles
// - Restart or up/down counter mode
// - Lock thresholds 127/111 through 1023/1007
// - Loop off holds gain at maximum
`timescale 1ns/1ns
`include "agt_cfg.svh"
module agt_top
	import agt_pkg::*;
#(
	parameter int STRENGTH_W = 8 // Width of the strength level
) (
	input wire logic i_mclk, // System clock
	input wire logic i_rstn, // Async reset, active low
	input wire logic [`AGT_ADDR_W-1:0] i_reg_addr, // Register address
	input wire logic [7:0] i_reg_wdata, // Register write data
	input wire logic i_reg_we, // Register write strobe
	output logic [7:0] o_reg_rdata, // Register read data
	input wire logic i_rx_on, // Receive chain powered
	input wire logic i_gain_loop_off, // Gain loop disabled
	input wire logic i_strength_valid, // New strength sample
	input wire logic [STRENGTH_W-1:0] i_strength, // Strength, 1.5 dB per step
	input wire logic i_cmp_valid, // Phase comparison done
	input wire logic [2:0] i_cmp_error, // Phase error, prescaler cycles
	input wire logic i_cal_done, // Calibration complete
	input wire logic i_seq_fault, // Sequencing fault
	input wire logic [8:0] i_int_sig, // Internal clocks and comparators
	output logic [4:0] o_vga_gain, // Amplifier gain setting
	output logic o_carrier_detect, // Strength above level
	output logic o_pll_locked, // Filtered lock status
	output logic o_status_pin // Selected status, mostly active low
);

	logic [7:0] reg_down;
	logic [7:0] reg_up;
	logic [7:0] reg_lock;
	logic [7:0] next_reg_down;
	logic [7:0] next_reg_up;
	logic [7:0] next_reg_lock;
	logic [4:0] gain;
	logic [4:0] next_gain;
	logic rx_on_d;
	logic carrier;
	logic next_carrier;
	logic pin;
	logic next_pin;
	logic [7:0] rdata;
	logic [7:0] next_rdata;
	logic [4:0] max_gain;
	logic [4:0] level;
	logic [7:0] up_th;
	logic [7:0] down_th;
	logic [STRENGTH_W:0] strength_x;
	logic [STRENGTH_W:0] up_x;
	logic [STRENGTH_W:0] down_x;
	logic [STRENGTH_W:0] level_x;

	agt_lock_if lk ();

	////////////////////////////////////////////////////////////////////////
	// Register writes and read mux
	always_comb begin
		next_reg_down = reg_down;
		next_reg_up = reg_up;
		next_reg_lock = reg_lock;
		if (i_reg_we) begin
			case (i_reg_addr)
				`AGT_OFS_GAIN_DOWN: next_reg_down = i_reg_wdata;
				`AGT_OFS_GAIN_UP: next_reg_up = i_reg_wdata;
				`AGT_OFS_LOCK_CTL: next_reg_lock = i_reg_wdata;
				default: next_reg_lock = reg_lock;
			endcase
		end
		case (i_reg_addr)
			`AGT_OFS_GAIN_DOWN: next_rdata = reg_down;
			`AGT_OFS_GAIN_UP: next_rdata = reg_up;
			`AGT_OFS_LOCK_CTL: next_rdata = reg_lock;
			default: next_rdata = 8'h00; // Unmapped reads as zero
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			reg_down <= `AGT_RST_GAIN_DOWN;
			reg_up <= `AGT_RST_GAIN_UP;
			reg_lock <= `AGT_RST_LOCK_CTL;
			rdata <= 8'h00;
		end else begin
			reg_down <= next_reg_down;
			reg_up <= next_reg_up;
			reg_lock <= next_reg_lock;
			rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Thresholds; sums are 8 bits wide, widened to one bit more than the strength only for the compares
	always_comb begin
		max_gain = reg_down[`AGT_LEVEL_HI:`AGT_LEVEL_LO];
		level = reg_up[`AGT_LEVEL_HI:`AGT_LEVEL_LO];
		up_th = 8'(level) + `AGT_UP_BASE + 8'(reg_up[`AGT_MARGIN_HI:`AGT_MARGIN_LO]);
		down_th = up_th + `AGT_DOWN_BASE
			+ 8'(reg_down[`AGT_MARGIN_HI:`AGT_MARGIN_LO]);
		strength_x = (STRENGTH_W+1)'(i_strength);
		up_x = (STRENGTH_W+1)'(up_th);
		down_x = (STRENGTH_W+1)'(down_th);
		level_x = (STRENGTH_W+1)'(level);
	end

	////////////////////////////////////////////////////////////////////////
	// Gain loop and carrier detect
	always_comb begin
		next_gain = gain;
		next_carrier = carrier;
		if (!i_rx_on || !rx_on_d) begin
			next_gain = max_gain;
		end else if (i_gain_loop_off) begin
			next_gain = max_gain;
		end else if (gain > max_gain) begin
			next_gain = max_gain;
		end else if (i_strength_valid) begin
			if (strength_x > down_x && gain != 5'h00) begin
				next_gain = gain - 5'h01;
			end else if (strength_x < up_x && gain < max_gain) begin
				next_gain = gain + 5'h01;
			end
		end
		if (!i_rx_on) begin
			next_carrier = 1'b0;
		end else if (i_strength_valid) begin
			next_carrier = strength_x > level_x;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			gain <= 5'h18;
			rx_on_d <= 1'b0;
			carrier <= 1'b0;
		end else begin
			gain <= next_gain;
			rx_on_d <= i_rx_on;
			carrier <= next_carrier;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Lock detector hookup
	assign lk.wide_window = reg_lock[`AGT_WIN_BIT];
	assign lk.mode = agt_lock_mode_type'(reg_lock[`AGT_MODE_BIT]);
	assign lk.accuracy = reg_lock[`AGT_ACC_HI:`AGT_ACC_LO];
	assign lk.cmp_valid = i_cmp_valid;
	assign lk.cmp_error = i_cmp_error;

	agt_lock_det u_lock (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.lk(lk)
	);

	////////////////////////////////////////////////////////////////////////
	// Status pin select; registered, so clocks routed out are delayed one cycle
	always_comb begin
		case (reg_lock[`AGT_SEL_HI:`AGT_SEL_LO])
			AGT_SRC_LOW: next_pin = 1'b0;
			AGT_SRC_HIGH: next_pin = 1'b1;
			AGT_SRC_LOCK_FILT: next_pin = ~lk.locked;
			AGT_SRC_LOCK_RAW: next_pin = ~lk.raw_in_window;
			AGT_SRC_CARRIER: next_pin = ~carrier;
			AGT_SRC_CAL: next_pin = ~i_cal_done;
			AGT_SRC_SEQ: next_pin = ~i_seq_fault;
			default: next_pin = i_int_sig[4'(reg_lock[`AGT_SEL_HI:`AGT_SEL_LO] - 4'h7)];
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			pin <= 1'b0;
		end else begin
			pin <= next_pin;
		end
	end

	assign o_reg_rdata = rdata;
	assign o_vga_gain = gain;
	assign o_carrier_detect = carrier;
	assign o_pll_locked = lk.locked;
	assign o_status_pin = pin;

endmodule : agt_top

// [tb/agt_monitor.sv]
// Port-level checks for the gain and lock block
`timescale 1ns/1ns
module agt_monitor #(
	parameter int STRENGTH_W = 8 // Strength width
) (
	input wire logic i_mclk, // Clock
	input wire logic i_rstn, // Reset
	input wire logic [6:0] i_reg_addr, // Address
	input wire logic [7:0] i_reg_wdata, // Data
	input wire logic i_reg_we, // Strobe
	input wire logic i_rx_on, // Rx on
	input wire logic i_gain_loop_off, // Loop off
	input wire logic i_strength_valid, // Sample
	input wire logic [STRENGTH_W-1:0] i_strength, // Strength
	input wire logic i_cmp_valid, // Compare
	input wire logic [2:0] i_cmp_error, // Error
	input wire logic [8:0] i_int_sig, // Internal
	input wire logic [4:0] o_vga_gain, // Gain
	input wire logic o_carrier_detect, // Carrier
	input wire logic o_pll_locked, // Lock
	input wire logic o_status_pin // Pin
);
	logic [7:0] dn_q, up_q, lk_q, next_dn, next_up, next_lk, thr_up, thr_dn;
	logic pick;
	logic run;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	// Shadow registers, so thresholds are known without looking inside
	always_comb begin
		next_dn = dn_q;
		next_up = up_q;
		next_lk = lk_q;
		if (i_reg_we && i_reg_addr == 7'h13) next_dn = i_reg_wdata;
		if (i_reg_we && i_reg_addr == 7'h14) next_up = i_reg_wdata;
		if (i_reg_we && i_reg_addr == 7'h15) next_lk = i_reg_wdata;
	end
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			dn_q <= 8'h38;
			up_q <= 8'h38;
			lk_q <= 8'h00;
		end else begin
			dn_q <= next_dn;
			up_q <= next_up;
			lk_q <= next_lk;
		end
	end
	// Gain thresholds; a write in the same cycle is excluded as ambiguous
	assign thr_up = {3'h0, up_q[4:0]} + 8'h08 + {5'h0, up_q[7:5]};
	assign thr_dn = thr_up + 8'h03 + {5'h0, dn_q[7:5]};
	assign run = i_rx_on && !i_gain_loop_off && !i_reg_we && o_vga_gain <= dn_q[4:0];
	assign pick = i_int_sig[lk_q[7:4] - 4'h7];
	////////////////////////////////////////////////////////////////////////////
	gain_down_a: assert property (run && $past(i_rx_on) && i_strength_valid
		&& i_strength > thr_dn && o_vga_gain != 5'h00 |=> o_vga_gain == $past(o_vga_gain) - 5'h01)
		else $error("gain did not step down");
	gain_up_a: assert property (run && $past(i_rx_on) && i_strength_valid
		&& i_strength < thr_up && o_vga_gain < dn_q[4:0] |=> o_vga_gain == $past(o_vga_gain) + 5'h01)
		else $error("gain did not step up");
	gain_cap_a: assert property (!$past(i_reg_we) |-> o_vga_gain <= dn_q[4:0])
		else $error("gain above maximum");
	gain_fixed_a: assert property ((!i_rx_on || i_gain_loop_off) && !i_reg_we
		|=> o_vga_gain == dn_q[4:0])
		else $error("gain not held at maximum");
	carrier_a: assert property (i_rx_on && i_strength_valid && !i_reg_we
		|=> o_carrier_detect == ($past(i_strength) > up_q[4:0]))
		else $error("carrier detect wrong");
	pin_fixed_a: assert property (lk_q[7:5] == 3'h0 |=> o_status_pin == $past(lk_q[4]))
		else $error("fixed pin level wrong");
	pin_lock_a: assert property (lk_q[7:4] == 4'h2 |=> o_status_pin == !$past(o_pll_locked))
		else $error("pin lock wrong");
	pin_carrier_a: assert property (lk_q[7:4] == 4'h4
		|=> o_status_pin == !$past(o_carrier_detect))
		else $error("pin carrier wrong");
	pin_route_a: assert property (lk_q[7:4] > 4'h6 |=> o_status_pin == $past(pick))
		else $error("pin routing wrong");
	lock_drop_a: assert property (!lk_q[2] && o_pll_locked && i_cmp_valid
		&& i_cmp_error >= (lk_q[3] ? 3'h4 : 3'h2) |-> ##[1:3] !o_pll_locked)
		else $error("lock held after a miss");
endmodule : agt_monitor
bind agt_top agt_monitor #(.STRENGTH_W(STRENGTH_W)) mon (.*);

// [tb/agt_host_model.sv]
// Host controller model on the parallel register port
`timescale 1ns/1ns
module agt_host_model (
	input wire logic i_mclk, // Clock
	input wire logic [7:0] i_rdata, // Read data
	output logic [6:0] o_addr, // Address
	output logic [7:0] o_wdata, // Write data
	output logic o_we // Write strobe
);
	// Idle port from time zero
	initial begin
		o_addr = 7'h00;
		o_wdata = 8'h00;
		o_we = 1'b0;
	end
	// One-cycle strobe, so a later call always lets an edge pass first
	task wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge i_mclk) o_addr <= a;
		o_wdata <= d;
		o_we <= 1'b1;
		@(posedge i_mclk) o_we <= 1'b0;
	endtask : wr
	// Read data is registered one edge after the address; take it at the falling edge
	task rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge i_mclk) o_addr <= a;
		@(posedge i_mclk);
		@(negedge i_mclk) d = i_rdata;
	endtask : rd
	// Route the lock state to the status pin
	task lock_pin(input logic [3:0] ctl);
		wr(7'h15, {4'h2, ctl});
	endtask : lock_pin
endmodule : agt_host_model

// [tb/tb_top.sv]
// Self-checking bench for the gain and lock block
`timescale 1ns/1ns
module tb_top;
	logic i_mclk = 1'b0;
	logic i_rstn = 1'b0;
	logic rx = 1'b0, off = 1'b0, sv = 1'b0, cv = 1'b0, cal = 1'b1, seq = 1'b0;
	logic [7:0] str = 8'h00, rd, wdata, rdata;
	logic [2:0] err = 3'h0;
	logic [8:0] isig = 9'h0a5;
	logic [6:0] addr;
	logic we, car, lck, pin;
	logic [4:0] gain;
	int num_errors = 0, cmp_count = 0, k;
	always #50 i_mclk = ~i_mclk;
	agt_host_model host (.i_mclk(i_mclk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
		.o_we(we));
	agt_top uut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_reg_we(we), .o_reg_rdata(rdata), .i_rx_on(rx), .i_gain_loop_off(off),
		.i_strength_valid(sv), .i_strength(str), .i_cmp_valid(cv), .i_cmp_error(err),
		.i_cal_done(cal), .i_seq_fault(seq), .i_int_sig(isig), .o_vga_gain(gain),
		.o_carrier_detect(car), .o_pll_locked(lck), .o_status_pin(pin));
	////////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task results;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results
	// One strength sample; outputs are read at the following falling edge
	task sample(input logic [7:0] s);
		@(posedge i_mclk) sv <= 1'b1;
		str <= s;
		@(posedge i_mclk) sv <= 1'b0;
		@(negedge i_mclk);
	endtask : sample
	// Phase comparisons on alternate cycles, then time for lock and pin
	task compare(input int cnt, input logic [2:0] e);
		repeat (cnt) begin
			@(posedge i_mclk) cv <= 1'b1;
			err <= e;
			@(posedge i_mclk) cv <= 1'b0;
		end
		repeat (4) @(negedge i_mclk);
	endtask : compare
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge i_mclk);
		i_rstn <= 1'b1;
		@(negedge i_mclk);
		chk("gain", gain, 10'h018);
		// An ignored write to an unmapped slot, then the reset values read back
		host.wr(7'h16, 8'h5a);
		for (k = 0; k < 4; k++) begin
			host.rd(7'h13 + k[6:0], rd);
			chk("reg", rd, k < 2 ? 10'h038 : 10'h000);
		end
		@(posedge i_mclk) rx <= 1'b1;
		// Every lowering margin at and just past its threshold
		for (k = 0; k < 8; k++) begin
			host.wr(7'h13, {k[2:0], 5'h18});
			sample(8'h24 + k[7:0]);
			chk("gain", gain, 10'h018);
			sample(8'h25 + k[7:0]);
			chk("gain", gain, 10'h017);
			sample(8'h20);
			chk("gain", gain, 10'h018);
		end
		// Every raising margin at and just below its threshold
		for (k = 0; k < 8; k++) begin
			host.wr(7'h14, {k[2:0], 5'h18});
			sample(8'h3f);
			sample(8'h20 + k[7:0]);
			chk("gain", gain, 10'h017);
			sample(8'h1f + k[7:0]);
			chk("gain", gain, 10'h018);
		end
		sample(8'h00);
		chk("gain", gain, 10'h018);
		host.wr(7'h13, 8'h0a);
		// The clamp follows the write by one edge
		repeat (2) @(negedge i_mclk);
		chk("gain", gain, 10'h00a);
		@(posedge i_mclk) off <= 1'b1;
		host.wr(7'h13, 8'h0e);
		sample(8'h00);
		chk("gain", gain, 10'h00e);
		@(posedge i_mclk) off <= 1'b0;
		rx <= 1'b0;
		host.wr(7'h13, 8'h10);
		@(posedge i_mclk) rx <= 1'b1;
		@(negedge i_mclk);
		chk("gain", gain, 10'h010);
		// Carrier against the shared level, seen on the pin
		host.wr(7'h15, 8'h40);
		sample(8'h18);
		@(negedge i_mclk);
		chk("carrier", car, 10'h000);
		chk("pin", pin, 10'h001);
		sample(8'h19);
		@(negedge i_mclk);
		chk("pin", pin, 10'h000);
		// Each accuracy code, windows alternating, one short then exact
		for (k = 0; k < 4; k++) begin
			host.lock_pin({k[0], 1'b0, k[1:0]});
			compare(1, k[0] ? 3'h4 : 3'h2);
			chk("locked", lck, 10'h000);
			compare((128 << k) - 2, k[0] ? 3'h3 : 3'h1);
			chk("locked", lck, 10'h000);
			compare(1, k[0] ? 3'h3 : 3'h1);
			chk("locked", lck, 10'h001);
			chk("pin", pin, 10'h000);
		end
		// Up/down counting drops lock only sixteen below the lock count
		host.lock_pin(4'h0);
		compare(1, 3'h2);
		host.lock_pin(4'h4);
		compare(127, 3'h1);
		compare(15, 3'h2);
		chk("locked", lck, 10'h001);
		compare(1, 3'h2);
		chk("locked", lck, 10'h000);
		compare(1, 3'h1);
		chk("locked", lck, 10'h000);
		// Every pin source code
		for (k = 0; k < 16; k++) begin
			host.wr(7'h15, {k[3:0], 4'h4});
			repeat (2) @(negedge i_mclk);
			chk("pin", pin, 10'((16'h52c6 >> k) & 16'h0001));
		end
		results();
	end
endmodule : tb_top
